// file: inc/cbt_consts.vh
// Constants for the CAN bit timing and message object access block
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CBT_OFF_PAGE 8'h00
`define CBT_OFF_CFG 8'h04
`define CBT_OFF_BTR 8'h08
`define CBT_OFF_PRESCALER_EXTENSION_FIELD 8'h0C
`define CBT_OFF_STAT 8'h10
`define CBT_OFF_IF1 8'h20
`define CBT_OFF_IF2 8'h40
`define CBT_OFF_VALID 8'h60
`define CBT_OFF_TXRQ 8'h64
`define CBT_OFF_NEWDAT 8'h68
`define CBT_OFF_INTPND 8'h6C

// ****************************************
// Interface set sub-offsets (word index)
// ****************************************
`define CBT_IF_CMD 3'h0
`define CBT_IF_ARB 3'h1
`define CBT_IF_CTRL 3'h2
`define CBT_IF_DATA_A 3'h3
`define CBT_IF_DATA_B 3'h4

// ****************************************
// Reset values and page
// ****************************************
`define CBT_CAN_PAGE 8'h0C
`define CBT_BTR_RST 16'h2300
`define CBT_PRESCALER_EXTENSION_FIELD_RST 4'h0
`define CBT_CFG_RST 2'h0

// ****************************************
// Field positions
// ****************************************
`define CBT_BTR_PRESC 5:0
`define CBT_BTR_SJW 7:6
`define CBT_BTR_TIME_SEGMENT_ONE_FIELD 11:8
`define CBT_BTR_TIME_SEGMENT_TWO_FIELD 14:12
`define CBT_CMD_OBJ 5:0
`define CBT_CMD_DIR 7
`define CBT_CMD_BUSY 15
`define CBT_ARB_VALID 31
`define CBT_CTRL_NEWDAT 15
`define CBT_CTRL_INTPND 13
`define CBT_CTRL_TXRQST 8

// ****************************************
// Bit phase and transfer states
// ****************************************
`define CBT_PH_SYNC 2'h0
`define CBT_PH_SEG1 2'h1
`define CBT_PH_SEG2 2'h2
`define CBT_XF_IDLE 1'b0
`define CBT_XF_READ 1'b1

`endif

// file: verilog/cbt_obj_ram.v
// Message object memory with registered read data
`timescale 1ns/1ns
`default_nettype none

module cbt_obj_ram #(
	parameter DW = 112,
	parameter AW = 5
) (
	// Clock
	input wire clock,
	// Access port
	input wire we,
	input wire re,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end

endmodule // cbt_obj_ram

`default_nettype wire

// file: verilog/cbt_core.v
// CAN bit timing generator and register access with message objects
`timescale 1ns/1ns
`default_nettype none
`include "cbt_consts.vh"

module cbt_core #(
	parameter NOBJ = 32
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Bit timing strobes
	output reg core_tick_q,
	output reg tq_tick_q,
	output reg bit_start_q,
	output reg sample_point_q
);

	// ****************************************
	// Configuration registers and bit timing counters
	// ****************************************
	reg [7:0] page_q;
	reg [1:0] cfg_q;
	reg [15:0] btr_q;
	reg [3:0] prescaler_extension_field_q;
	reg [2:0] div_cnt_q;
	reg [9:0] tq_cnt_q;
	reg [1:0] phase_q;
	reg [3:0] seg_cnt_q;

	wire [3:0] div_ratio = 4'h1 << cfg_q;
	wire [2:0] wr_delay = div_ratio[2:0] - 3'h1;
	wire [9:0] presc_m1 = {prescaler_extension_field_q, btr_q[`CBT_BTR_PRESC]};
	wire core_fire = (div_cnt_q == wr_delay);
	wire tq_fire = core_fire && (tq_cnt_q == presc_m1);
	wire [3:0] time_segment_one_field_m1 = btr_q[`CBT_BTR_TIME_SEGMENT_ONE_FIELD];
	wire [3:0] time_segment_two_field_m1 = {1'b0, btr_q[`CBT_BTR_TIME_SEGMENT_TWO_FIELD]};

	// ****************************************
	// Bus handshake
	// ****************************************
	reg pw_busy_q;
	reg [2:0] pw_cnt_q;
	reg [7:0] pw_addr_q;
	reg [31:0] pw_data_q;
	reg [31:0] rd_d;
	reg err_d;
	wire on_page = (page_q == `CBT_CAN_PAGE);
	wire is_if = (paddr[7:5] == 3'h1) || (paddr[7:5] == 3'h2);
	wire is_hdl = (paddr[7:4] == 4'h6);
	wire wr_ok = psel && penable && pready && pwrite && !pslverr;
	wire cm_now = wr_ok && (wr_delay == 3'h0);
	wire cm_late = pw_busy_q && (pw_cnt_q == 3'h1);
	wire cm_en = cm_now || cm_late;
	wire [7:0] cm_addr = cm_now ? paddr : pw_addr_q;
	wire [31:0] cm_data = cm_now ? pwdata : pw_data_q;

	// ****************************************
	// Interface sets, handler flags, transfer engine
	// ****************************************
	reg [31:0] if_arb_q [0:1];
	reg [15:0] if_ctrl_q [0:1];
	reg [31:0] if_da_q [0:1];
	reg [31:0] if_db_q [0:1];
	reg [5:0] if_obj_q [0:1];
	reg [1:0] if_dir_q;
	reg [1:0] req_q;
	reg xf_state_q;
	reg xf_set_q;
	reg [NOBJ-1:0] valid_q;
	reg [NOBJ-1:0] txrq_q;
	reg [NOBJ-1:0] newdat_q;
	reg [NOBJ-1:0] intpnd_q;
	wire [111:0] ram_rdata;
	reg ram_we;
	reg ram_re;
	reg [4:0] ram_addr;
	reg [111:0] ram_wdata;
	reg sel_set;
	integer i;

	// Memory port driven by the transfer engine
	always @* begin
		sel_set = req_q[0] ? 1'b0 : 1'b1;
		ram_we = 1'b0;
		ram_re = 1'b0;
		ram_addr = if_obj_q[sel_set][4:0] - 5'h1;
		ram_wdata = {if_arb_q[sel_set], if_ctrl_q[sel_set], if_da_q[sel_set], if_db_q[sel_set]};
		if (xf_state_q == `CBT_XF_IDLE && req_q != 2'h0) begin
			ram_we = if_dir_q[sel_set];
			ram_re = !if_dir_q[sel_set];
		end
	end

	cbt_obj_ram #(.DW(112), .AW(5)) u_ram (
		.clock(clock),
		.we(ram_we),
		.re(ram_re),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	always @(posedge clock) begin
		if (!resetn) begin
			for (i = 0; i < 2; i = i + 1) begin
				if_arb_q[i] <= 32'h00000000;
				if_ctrl_q[i] <= 16'h0000;
				if_da_q[i] <= 32'h00000000;
				if_db_q[i] <= 32'h00000000;
				if_obj_q[i] <= 6'h01;
			end
			if_dir_q <= 2'h0;
			req_q <= 2'h0;
			xf_state_q <= `CBT_XF_IDLE;
			xf_set_q <= 1'b0;
			valid_q <= {NOBJ{1'b0}};
			txrq_q <= {NOBJ{1'b0}};
			newdat_q <= {NOBJ{1'b0}};
			intpnd_q <= {NOBJ{1'b0}};
		end else begin
			if (cm_en && (cm_addr[7:5] == 3'h1 || cm_addr[7:5] == 3'h2)) begin
				case (cm_addr[4:2])
					`CBT_IF_CMD: begin
						if (cm_data[5:0] != 6'h00 && cm_data[5:0] <= NOBJ) begin
							if_obj_q[cm_addr[6]] <= cm_data[`CBT_CMD_OBJ];
							if_dir_q[cm_addr[6]] <= cm_data[`CBT_CMD_DIR];
							req_q[cm_addr[6]] <= 1'b1;
						end
					end
					`CBT_IF_ARB: if_arb_q[cm_addr[6]] <= cm_data;
					`CBT_IF_CTRL: if_ctrl_q[cm_addr[6]] <= cm_data[15:0];
					`CBT_IF_DATA_A: if_da_q[cm_addr[6]] <= cm_data;
					`CBT_IF_DATA_B: if_db_q[cm_addr[6]] <= cm_data;
					default: ;
				endcase
			end
			case (xf_state_q)
				`CBT_XF_IDLE: begin
					if (req_q != 2'h0) begin
						req_q[sel_set] <= 1'b0;
						xf_set_q <= sel_set;
						if (if_dir_q[sel_set]) begin
							valid_q[ram_addr] <= if_arb_q[sel_set][`CBT_ARB_VALID];
							txrq_q[ram_addr] <= if_ctrl_q[sel_set][`CBT_CTRL_TXRQST];
							newdat_q[ram_addr] <= if_ctrl_q[sel_set][`CBT_CTRL_NEWDAT];
							intpnd_q[ram_addr] <= if_ctrl_q[sel_set][`CBT_CTRL_INTPND];
						end else begin
							xf_state_q <= `CBT_XF_READ;
						end
					end
				end
				`CBT_XF_READ: begin
					if_arb_q[xf_set_q] <= ram_rdata[111:80];
					if_ctrl_q[xf_set_q] <= ram_rdata[79:64];
					if_da_q[xf_set_q] <= ram_rdata[63:32];
					if_db_q[xf_set_q] <= ram_rdata[31:0];
					xf_state_q <= `CBT_XF_IDLE;
				end
				default: xf_state_q <= `CBT_XF_IDLE;
			endcase
		end
	end

	// ****************************************
	// Configuration commit with divider delay
	// ****************************************
	always @(posedge clock) begin
		if (!resetn) begin
			page_q <= 8'h00;
			cfg_q <= `CBT_CFG_RST;
			btr_q <= `CBT_BTR_RST;
			prescaler_extension_field_q <= `CBT_PRESCALER_EXTENSION_FIELD_RST;
			pw_busy_q <= 1'b0;
			pw_cnt_q <= 3'h0;
			pw_addr_q <= 8'h00;
			pw_data_q <= 32'h00000000;
		end else begin
			if (wr_ok && wr_delay != 3'h0) begin
				pw_busy_q <= 1'b1;
				pw_cnt_q <= wr_delay;
				pw_addr_q <= paddr;
				pw_data_q <= pwdata;
			end else if (pw_busy_q) begin
				pw_cnt_q <= pw_cnt_q - 3'h1;
				pw_busy_q <= (pw_cnt_q != 3'h1);
			end
			if (cm_en) begin
				case (cm_addr)
					`CBT_OFF_PAGE: page_q <= cm_data[7:0];
					`CBT_OFF_CFG: cfg_q <= cm_data[1:0];
					`CBT_OFF_BTR: btr_q <= {1'b0, cm_data[14:0]};
					`CBT_OFF_PRESCALER_EXTENSION_FIELD: prescaler_extension_field_q <= cm_data[3:0];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Read mux and decode
	// ****************************************
	always @* begin
		rd_d = 32'h00000000;
		err_d = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			err_d = 1'b1;
		end else if (paddr == `CBT_OFF_PAGE) begin
			rd_d = {24'h000000, page_q};
		end else if (!on_page) begin
			err_d = 1'b1;
		end else if (is_if) begin
			case (paddr[4:2])
				`CBT_IF_CMD: rd_d = {16'h0000, req_q[paddr[6]], 7'h00,
					if_dir_q[paddr[6]], 1'b0, if_obj_q[paddr[6]]};
				`CBT_IF_ARB: rd_d = if_arb_q[paddr[6]];
				`CBT_IF_CTRL: rd_d = {16'h0000, if_ctrl_q[paddr[6]]};
				`CBT_IF_DATA_A: rd_d = if_da_q[paddr[6]];
				`CBT_IF_DATA_B: rd_d = if_db_q[paddr[6]];
				default: err_d = 1'b1;
			endcase
		end else if (is_hdl) begin
			err_d = pwrite;
			case (paddr)
				`CBT_OFF_VALID: rd_d = valid_q;
				`CBT_OFF_TXRQ: rd_d = txrq_q;
				`CBT_OFF_NEWDAT: rd_d = newdat_q;
				`CBT_OFF_INTPND: rd_d = intpnd_q;
				default: err_d = 1'b1;
			endcase
		end else begin
			case (paddr)
				`CBT_OFF_CFG: rd_d = {30'h0, cfg_q};
				`CBT_OFF_BTR: rd_d = {16'h0000, btr_q};
				`CBT_OFF_PRESCALER_EXTENSION_FIELD: rd_d = {28'h0000000, prescaler_extension_field_q};
				`CBT_OFF_STAT: begin
					rd_d = {16'h0000, 4'h0, seg_cnt_q, 6'h00, phase_q};
					err_d = pwrite;
				end
				default: err_d = 1'b1;
			endcase
		end
	end

	always @(posedge clock) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready && !(pwrite && pw_busy_q)) begin
			prdata <= pwrite ? 32'h00000000 : rd_d;
			pslverr <= err_d;
			pready <= 1'b1;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// Core clock, time quantum and bit segments
	// ****************************************
	always @(posedge clock) begin
		if (!resetn) begin
			div_cnt_q <= 3'h0;
			tq_cnt_q <= 10'h000;
			phase_q <= `CBT_PH_SYNC;
			seg_cnt_q <= 4'h0;
			core_tick_q <= 1'b0;
			tq_tick_q <= 1'b0;
			bit_start_q <= 1'b0;
			sample_point_q <= 1'b0;
		end else begin
			core_tick_q <= core_fire;
			tq_tick_q <= tq_fire;
			bit_start_q <= 1'b0;
			sample_point_q <= 1'b0;
			div_cnt_q <= core_fire ? 3'h0 : div_cnt_q + 3'h1;
			if (core_fire) begin
				tq_cnt_q <= tq_fire ? 10'h000 : tq_cnt_q + 10'h001;
			end
			if (tq_fire) begin
				case (phase_q)
					`CBT_PH_SYNC: phase_q <= `CBT_PH_SEG1;
					`CBT_PH_SEG1: begin
						if (seg_cnt_q == time_segment_one_field_m1) begin
							phase_q <= `CBT_PH_SEG2;
							seg_cnt_q <= 4'h0;
							sample_point_q <= 1'b1;
						end else begin
							seg_cnt_q <= seg_cnt_q + 4'h1;
						end
					end
					`CBT_PH_SEG2: begin
						if (seg_cnt_q == time_segment_two_field_m1) begin
							phase_q <= `CBT_PH_SYNC;
							seg_cnt_q <= 4'h0;
							bit_start_q <= 1'b1;
						end else begin
							seg_cnt_q <= seg_cnt_q + 4'h1;
						end
					end
					default: phase_q <= `CBT_PH_SYNC;
				endcase
			end
		end
	end

endmodule // cbt_core

`default_nettype wire

// file: verif/cbt_chk.sv
// Assertion checker for the CAN timing core
`timescale 1ns/1ns
`default_nettype none
module cbt_chk (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Strobes
	input wire core_tick_q,
	input wire tq_tick_q,
	input wire bit_start_q,
	input wire sample_point_q
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_in_acc; pready |-> psel && penable; endproperty
	a_in_acc: assert property (p_in_acc) else $error("ready outside access");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_align; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_align: assert property (p_align) else $error("misaligned accepted");
	property p_ro; pready && pwrite && (paddr == 8'h10 || paddr[7:4] == 4'h6) |-> pslverr; endproperty
	a_ro: assert property (p_ro) else $error("read only written");
	property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error data nonzero");
	property p_quiet; $rose(resetn) |-> !(pready || tq_tick_q || bit_start_q); endproperty
	a_quiet: assert property (p_quiet) else $error("active after reset");
	property p_apart; bit_start_q |-> !sample_point_q; endproperty
	a_apart: assert property (p_apart) else $error("sample in sync");
	c_err: cover property (pslverr);
	c_bit: cover property (bit_start_q);
	c_read: cover property (pready && !pwrite);
endmodule // cbt_chk
bind cbt_core cbt_chk u_cbt_chk (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .core_tick_q(core_tick_q), .tq_tick_q(tq_tick_q),
	.bit_start_q(bit_start_q), .sample_point_q(sample_point_q));
`default_nettype wire

// file: verif/cbt_bit_mon.sv
// Far side observer measuring the bit timing strobes
`timescale 1ns/1ns
`default_nettype none
module cbt_bit_mon (
	// Clock
	input wire logic clock,
	// Strobes
	input wire logic core_tick_q,
	input wire logic tq_tick_q,
	input wire logic bit_start_q,
	input wire logic sample_point_q,
	// Measured spans
	output logic [15:0] core_gap,
	output logic [15:0] tq_gap,
	output logic [15:0] bit_tq,
	output logic [15:0] samp_tq
);
	logic [15:0] cc_q = 16'h0;
	logic [15:0] ct_q = 16'h0;
	logic [15:0] nb_q = 16'h0;
	always @(posedge clock) begin
		cc_q <= core_tick_q ? 16'h1 : cc_q + 16'h1;
		ct_q <= tq_tick_q ? 16'h1 : ct_q + 16'h1;
		nb_q <= bit_start_q ? 16'h0 : nb_q + {15'h0, tq_tick_q};
		if (core_tick_q) core_gap <= cc_q;
		if (tq_tick_q) tq_gap <= ct_q;
		if (bit_start_q) bit_tq <= nb_q + {15'h0, tq_tick_q};
		if (sample_point_q) samp_tq <= nb_q + {15'h0, tq_tick_q};
	end
endmodule // cbt_bit_mon
`default_nettype wire

// file: verif/cbt_core_bench.sv
// Self-checking bench for the CAN timing core
`timescale 1ns/1ns
`default_nettype none
module cbt_core_bench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, core_tick_q, tq_tick_q, bit_start_q, sample_point_q, er;
	logic [15:0] core_gap, tq_gap, bit_tq, samp_tq;
	int err_total = 0;
	int cmp_count = 0;
	always #5 clock = ~clock;
	cbt_core u_cbt_core (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_tick_q(core_tick_q), .tq_tick_q(tq_tick_q),
		.bit_start_q(bit_start_q), .sample_point_q(sample_point_q));
	cbt_bit_mon u_cbt_bit_mon (.clock(clock), .core_tick_q(core_tick_q), .tq_tick_q(tq_tick_q),
		.bit_start_q(bit_start_q), .sample_point_q(sample_point_q), .core_gap(core_gap),
		.tq_gap(tq_gap), .bit_tq(bit_tq), .samp_tq(samp_tq));
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1, "ready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp, input logic xe, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
		chk({31'h0, er}, {31'h0, xe}, "read error");
	endtask
	task wchk(input logic [7:0] a, input logic [31:0] d, input logic xe);
		apb(1'b1, a, d);
		chk({31'h0, er}, {31'h0, xe}, "write error");
	endtask
	task xfer(input logic [7:0] a, input logic [31:0] cmd);
		wchk(a, cmd, 1'b0);
		repeat (8) @(posedge clock);
		rd = 32'hFFFF;
		for (int i = 0; i < 10 && rd[15] !== 1'b0; i++) apb(1'b0, a, 32'h0);
		chk({31'h0, rd[15]}, 32'h0, "busy");
	endtask
	initial begin
		#100000;
		err_total++;
		close_out;
	end
	initial begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		rchk(8'h08, 32'h0, 1'b1, "page closed");
		wchk(8'h00, 32'h0C, 1'b0);
		rchk(8'h08, 32'h2300, 1'b0, "timing word");
		rchk(8'h0C, 32'h0, 1'b0, "extension");
		rchk(8'h04, 32'h0, 1'b0, "divider reset");
		$display("test reset done");
		wchk(8'h04, 32'h2, 1'b0);
		wchk(8'h08, 32'h6FC0, 1'b0);
		repeat (300) @(posedge clock);
		chk({16'h0, core_gap}, 32'h4, "core gap");
		chk({16'h0, tq_gap}, 32'h4, "tq gap");
		chk({16'h0, bit_tq}, 32'h18, "bit quanta");
		chk({16'h0, samp_tq}, 32'h11, "sample quanta");
		wchk(8'h08, 32'h6FC2, 1'b0);
		repeat (800) @(posedge clock);
		chk({16'h0, tq_gap}, 32'hC, "tq gap");
		chk({16'h0, bit_tq}, 32'h18, "bit quanta");
		rchk(8'h04, 32'h2, 1'b0, "divider");
		$display("test timing done");
		wchk(8'h10, 32'h1, 1'b1);
		wchk(8'h60, 32'h1, 1'b1);
		wchk(8'h6C, 32'h1, 1'b1);
		rchk(8'h02, 32'h0, 1'b1, "misaligned");
		$display("test access done");
		wchk(8'h24, 32'h80000000, 1'b0);
		wchk(8'h2C, 32'hA5A50F0F, 1'b0);
		xfer(8'h20, 32'h85);
		rchk(8'h60, 32'h10, 1'b0, "valid flags");
		xfer(8'h40, 32'h05);
		rchk(8'h4C, 32'hA5A50F0F, 1'b0, "set two data");
		xfer(8'h40, 32'hA0);
		rchk(8'h60, 32'h80000010, 1'b0, "valid flags");
		$display("test objects done");
		close_out;
	end
endmodule // cbt_core_bench
`default_nettype wire
